// ===== core/rtpm_pkg.sv
// Purpose: Types of the reloadable timer
// Assumes: Nothing
// Notes:   Mode field codes
package rtpm_pkg;

    typedef enum logic [1:0] {
        rtpm_m_timer   = 2'b00,
        rtpm_m_event   = 2'b01,
        rtpm_m_measure = 2'b10,
        rtpm_m_rsvd    = 2'b11
    } rtpm_mode_t;

endpackage

// ===== core/rtpm_timer.sv
// Purpose: 16-bit reloadable timer, event counter and pulse measurer with APB slave
// Assumes: event_capture_input synchronous-safe after two flops; zero-wait APB
// Notes:   int_req is a one-cycle pulse for an external interrupt controller
`timescale 1ns/100ps
`include "rtpm_timer_regs.svh"

module rtpm_timer
    import rtpm_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W  = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              event_capture_input,
    output logic                   int_req
);

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic             bus_setup;
    logic             bus_acc;
    logic             hit;
    logic             data_wr;
    logic             mode_wr;
    logic             start_wr;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] reload_r;
    logic [7:0]       mode_r;
    logic             run_r;
    logic             first_r;
    logic [31:0]      prdata_r;
    logic             int_req_r;
    rtpm_mode_t       mode_sel;

    assign bus_setup = psel & ~penable;
    assign bus_acc   = psel & penable;
    assign hit       = (paddr == ADDR_W'(`RTPM_OFS_START)) | (paddr == ADDR_W'(`RTPM_OFS_MODE))
                     | (paddr == ADDR_W'(`RTPM_OFS_DATA));
    assign data_wr   = bus_acc & pwrite & (paddr == ADDR_W'(`RTPM_OFS_DATA));
    assign mode_wr   = bus_acc & pwrite & (paddr == ADDR_W'(`RTPM_OFS_MODE));
    assign start_wr  = bus_acc & pwrite & (paddr == ADDR_W'(`RTPM_OFS_START));
    assign pready    = 1'b1;
    assign pslverr   = bus_acc & ~hit;
    assign prdata    = prdata_r;
    assign int_req   = int_req_r;
    assign mode_sel  = rtpm_mode_t'(mode_r[1:0]);

    ////////////////////////////////////////////////////////////////////////
    // Count clock prescaler

    logic [8:0] presc_r;
    logic [8:0] div_mask;
    logic       clk_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= 9'h000;
        end else begin
            presc_r <= presc_r + 9'h001;
        end
    end

    always_comb begin
        unique case (mode_r[`RTPM_F_CSEL_HI:`RTPM_F_CSEL_LO])
            2'b00: div_mask = `RTPM_DIV_MASK0;
            2'b01: div_mask = `RTPM_DIV_MASK1;
            2'b10: div_mask = `RTPM_DIV_MASK2;
            2'b11: div_mask = `RTPM_DIV_MASK3;
        endcase
    end

    assign clk_tick = ((presc_r & div_mask) == div_mask);

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser and edge detect

    logic ev_s1_r;
    logic ev_s2_r;
    logic ev_s3_r;
    logic ev_rise;
    logic ev_fall;
    logic ev_tick;
    logic meas_edge;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_s1_r <= 1'b0;
            ev_s2_r <= 1'b0;
            ev_s3_r <= 1'b0;
        end else begin
            ev_s1_r <= event_capture_input;
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
        end
    end

    assign ev_rise = ev_s2_r & ~ev_s3_r;
    assign ev_fall = ~ev_s2_r & ev_s3_r;

    always_comb begin
        unique case (mode_r[`RTPM_F_EDGE_HI:`RTPM_F_EDGE_LO])
            2'b00: ev_tick = ev_fall;
            2'b01: ev_tick = ev_rise;
            2'b10: ev_tick = ev_rise | ev_fall;
            2'b11: ev_tick = 1'b0;
        endcase
    end

    // Width: any edge ends one level; period: one edge kind only
    always_comb begin
        if (mode_r[`RTPM_F_EDGE_HI]) begin
            meas_edge = ev_rise | ev_fall;
        end else if (mode_r[`RTPM_F_EDGE_LO]) begin
            meas_edge = ev_rise;
        end else begin
            meas_edge = ev_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count qualifiers

    logic cnt_tick;
    logic meas_act;
    logic cap;
    logic meas_tick;
    logic cnt_zero;
    logic uflow;

    assign cnt_tick  = run_r & (((mode_sel == rtpm_m_timer) & clk_tick)
                     | ((mode_sel == rtpm_m_event) & ev_tick));
    assign meas_act  = run_r & (mode_sel == rtpm_m_measure);
    assign cap       = meas_act & meas_edge;
    assign meas_tick = meas_act & clk_tick & ~cap;
    assign cnt_zero  = (cnt_r == '0);
    assign uflow     = (cnt_tick & cnt_zero) | (meas_tick & (cnt_r == '1));

    ////////////////////////////////////////////////////////////////////////
    // Counter and reload register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= `RTPM_CNT_RESET;
        end else if (data_wr && !run_r) begin
            cnt_r <= pwdata[CNT_W-1:0];
        end else if (cap) begin
            cnt_r <= '0;
        end else if (meas_tick) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end else if (cnt_tick) begin
            cnt_r <= cnt_zero ? reload_r : cnt_r - CNT_W'(1);
        end
    end

    // A capture in the same cycle as a running write keeps the result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_r <= `RTPM_CNT_RESET;
        end else if (cap) begin
            reload_r <= cnt_r;
        end else if (data_wr) begin
            reload_r <= pwdata[CNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start flag, first-capture marker, request pulse

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 1'b0;
        end else if (start_wr) begin
            run_r <= pwdata[`RTPM_START_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_r <= 1'b0;
        end else if (start_wr && pwdata[`RTPM_START_BIT] && !run_r) begin
            first_r <= 1'b1;
        end else if (cap) begin
            first_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_req_r <= 1'b0;
        end else begin
            int_req_r <= (cnt_tick & cnt_zero) | (cap & ~first_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register; underflow set wins over the write clear

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= `RTPM_MODE_RESET;
        end else if (mode_wr) begin
            mode_r <= {pwdata[7:6], uflow, 1'b0, pwdata[3:0]};
        end else if (uflow) begin
            mode_r[`RTPM_F_UFLOW] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup phase

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (bus_setup && !pwrite) begin
            prdata_r <= 32'h0000_0000;
            if (paddr == ADDR_W'(`RTPM_OFS_START)) begin
                prdata_r[`RTPM_START_BIT] <= run_r;
            end else if (paddr == ADDR_W'(`RTPM_OFS_MODE)) begin
                prdata_r[7:0] <= mode_r;
            end else if (paddr == ADDR_W'(`RTPM_OFS_DATA)) begin
                prdata_r[CNT_W-1:0] <= (mode_sel == rtpm_m_measure) ? reload_r : cnt_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_stop_hold: assert property (!run_r && !data_wr |=> $stable(cnt_r))
        else $error("counter moved while stopped");

    chk_rsvd_hold: assert property ((mode_sel == rtpm_m_rsvd) && !data_wr |=> $stable(cnt_r))
        else $error("counter moved in reserved mode");

    chk_timer_reload: assert property (run_r && mode_sel == rtpm_m_timer && clk_tick && cnt_zero
        |=> cnt_r == $past(reload_r) && int_req && mode_r[`RTPM_F_UFLOW])
        else $error("timer underflow did not reload and request");

    chk_timer_dec: assert property (run_r && mode_sel == rtpm_m_timer && clk_tick && !cnt_zero && !data_wr
        |=> cnt_r == $past(cnt_r) - CNT_W'(1) && !int_req)
        else $error("timer did not decrement by one");

    chk_write_stopped: assert property (data_wr && !run_r
        ##1 1 |-> cnt_r == $past(pwdata[CNT_W-1:0]) && reload_r == $past(pwdata[CNT_W-1:0]))
        else $error("stopped write did not load counter and reload");

    chk_write_running: assert property (data_wr && run_r && !cnt_tick && !cap && !meas_tick
        |=> $stable(cnt_r) && reload_r == $past(pwdata[CNT_W-1:0]))
        else $error("running write disturbed counter");

    chk_event_edge: assert property (run_r && mode_sel == rtpm_m_event && mode_r[3:2] == 2'b01
        && ev_rise && !cnt_zero && !data_wr |=> cnt_r == $past(cnt_r) - CNT_W'(1))
        else $error("rising edge not counted");

    chk_meas_capture: assert property (cap |=> reload_r == $past(cnt_r) && cnt_r == '0)
        else $error("measurement capture wrong");

    chk_first_quiet: assert property (cap && first_r |=> !int_req ##1 !first_r || cap)
        else $error("first capture raised a request");

    chk_read_result: assert property (bus_setup && !pwrite && paddr == ADDR_W'(`RTPM_OFS_DATA)
        && mode_sel == rtpm_m_measure |=> prdata[CNT_W-1:0] == $past(reload_r))
        else $error("measure read did not return result");

    chk_uflow_clear: assert property (mode_wr && !uflow |=> !mode_r[`RTPM_F_UFLOW])
        else $error("mode write did not clear underflow flag");

    chk_event_fall: assert property (run_r && mode_sel == rtpm_m_event && mode_r[3:2] == 2'b00
        && ev_fall && !cnt_zero |=> cnt_r == $past(cnt_r) - CNT_W'(1))
        else $error("falling edge not counted");

    chk_event_both: assert property (run_r && mode_sel == rtpm_m_event && mode_r[3:2] == 2'b10
        && (ev_rise || ev_fall) && !cnt_zero |=> cnt_r == $past(cnt_r) - CNT_W'(1))
        else $error("edge of either kind not counted");

    chk_event_wrap: assert property (run_r && mode_sel == rtpm_m_event && ev_tick && cnt_zero
        |=> cnt_r == $past(reload_r) && int_req && mode_r[`RTPM_F_UFLOW])
        else $error("event underflow did not reload and request");

    chk_event_quiet: assert property (run_r && mode_sel == rtpm_m_event && !ev_tick |=> $stable(cnt_r))
        else $error("event counter moved without an edge");

    chk_meas_count: assert property (meas_tick |=> cnt_r == $past(cnt_r) + CNT_W'(1))
        else $error("measure counter did not count up");

    chk_later_request: assert property (cap && !first_r |=> int_req)
        else $error("later capture raised no request");

    chk_width_edge: assert property (meas_act && mode_r[`RTPM_F_EDGE_HI] && ev_s2_r != ev_s3_r
        |=> cnt_r == '0 && reload_r == $past(cnt_r))
        else $error("width edge did not capture");

    chk_period_skip: assert property (meas_act && !mode_r[`RTPM_F_EDGE_HI] && ev_s2_r != ev_s3_r
        && ev_s2_r != mode_r[`RTPM_F_EDGE_LO] && !data_wr |=> $stable(reload_r))
        else $error("unmeasured edge changed the result");

    chk_start_flag: assert property (start_wr |=> run_r == $past(pwdata[`RTPM_START_BIT]))
        else $error("start flag write not taken");

    chk_read_live: assert property (bus_setup && !pwrite && paddr == ADDR_W'(`RTPM_OFS_DATA)
        && mode_sel != rtpm_m_measure |=> prdata[CNT_W-1:0] == $past(cnt_r))
        else $error("read did not return live counter");

    chk_uflow_set: assert property (uflow |=> mode_r[`RTPM_F_UFLOW])
        else $error("underflow flag not set");

    chk_rsvd_quiet: assert property (mode_sel == rtpm_m_rsvd |=> !int_req)
        else $error("request raised in reserved mode");

    cov_timer_wrap: cover property (run_r && mode_sel == rtpm_m_timer && clk_tick && cnt_zero);
    cov_event_both: cover property (run_r && mode_sel == rtpm_m_event && mode_r[3:2] == 2'b10 && ev_fall);
    cov_meas_second: cover property (cap && !first_r ##1 int_req);
    cov_width_cap: cover property (cap && mode_r[`RTPM_F_EDGE_HI]);
    cov_event_wrap: cover property (run_r && mode_sel == rtpm_m_event && ev_tick && cnt_zero);

endmodule

// ===== core/rtpm_timer_regs.svh
// Purpose: Register map and constants of the reloadable timer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef RTPM_TIMER_REGS_SVH
`define RTPM_TIMER_REGS_SVH

// Register byte offsets
`define RTPM_OFS_START   8'h00
`define RTPM_OFS_MODE    8'h04
`define RTPM_OFS_DATA    8'h08

// Field positions
`define RTPM_START_BIT   0
`define RTPM_F_EDGE_LO   2
`define RTPM_F_EDGE_HI   3
`define RTPM_F_UFLOW     5
`define RTPM_F_CSEL_LO   6
`define RTPM_F_CSEL_HI   7

// Reset values
`define RTPM_MODE_RESET  8'h20
`define RTPM_CNT_RESET   16'h0000

// Prescaler tick masks for the four count clocks
`define RTPM_DIV_MASK0   9'h001
`define RTPM_DIV_MASK1   9'h00f
`define RTPM_DIV_MASK2   9'h03f
`define RTPM_DIV_MASK3   9'h1ff

`endif

// ===== verification/rtpm_pulse_src.sv
// Purpose: External pulse source driving the event input
// Assumes: Level held between toggles; starts low after reset
// Notes:   go loads a burst of toggles spaced half_len cycles
`timescale 1ns/100ps

module rtpm_pulse_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic [7:0] half_len,
    input  wire logic [7:0] toggles,
    output logic            event_capture_input
);
    logic [7:0] tmr_r;
    logic [7:0] left_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_capture_input <= 1'b0;
            tmr_r               <= 8'h00;
            left_r              <= 8'h00;
        end else if (go) begin
            left_r <= toggles;
            tmr_r  <= half_len;
        end else if (left_r != 8'h00) begin
            if (tmr_r <= 8'h01) begin
                event_capture_input <= ~event_capture_input;
                tmr_r               <= half_len;
                left_r              <= left_r - 8'h01;
            end else begin
                tmr_r <= tmr_r - 8'h01;
            end
        end
    end
endmodule

// ===== verification/tb.sv
// Purpose: Self-checking bench of the reloadable timer
// Assumes: Zero-wait APB slave, pulse source partner
// Notes:   Random reloads and burst lengths from a fixed seed
`timescale 1ns/100ps
`include "rtpm_timer_regs.svh"

module tb;
    import rtpm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, int_req, evt, go;
    logic [7:0]  paddr, half_len, toggles;
    logic [31:0] pwdata, prdata, rd;
    logic        er;
    int          err_total, num_checks, cyc, ints, int_last, int_gap, seed, r, k, n0;
    int          div_tab[4] = '{2, 16, 64, 512};

    rtpm_timer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_capture_input(evt), .int_req(int_req));
    rtpm_pulse_src src_u (.pclk(pclk), .presetn(presetn), .go(go), .half_len(half_len),
        .toggles(toggles), .event_capture_input(evt));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (int_req === 1'b1) begin
            ints     <= ints + 1;
            int_gap  <= cyc - int_last;
            int_last <= cyc;
        end
        if (cyc == 60000) begin
            err_total++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask

    task automatic burst(input int h, input int t);
        half_len <= h[7:0];
        toggles  <= t[7:0];
        go       <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        wait_cyc(h * t + 12);
    endtask

    task automatic test_done();
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h72d9;
        {presetn, psel, penable, pwrite, go} = 5'b00000;
        {paddr, half_len, toggles, pwdata} = '0;
        {err_total, num_checks, cyc, ints, int_last, int_gap} = '0;
        wait_cyc(5);
        presetn <= 1'b1;
        apb(`RTPM_OFS_MODE, 1'b0, 0);   chk(rd, 32'h20);
        apb(`RTPM_OFS_DATA, 1'b0, 0);   chk(rd, 32'h0);
        apb(8'h3c, 1'b0, 0);            chk({er, rd[30:0]}, 32'h80000000);
        // Clock select and reload period, all four count clocks
        for (int cs = 0; cs < 4; cs++) begin
            r = ($random(seed) & 7) + 1;
            apb(`RTPM_OFS_START, 1'b1, 0);
            apb(`RTPM_OFS_DATA, 1'b1, r);
            apb(`RTPM_OFS_DATA, 1'b0, 0); chk(rd, r);
            apb(`RTPM_OFS_MODE, 1'b1, cs << 6);
            apb(`RTPM_OFS_MODE, 1'b0, 0); chk(rd, cs << 6);
            apb(`RTPM_OFS_START, 1'b1, 1);
            wait_cyc((r + 1) * div_tab[cs] * 3);
            chk(int_gap, (r + 1) * div_tab[cs]);
        end
        apb(`RTPM_OFS_MODE, 1'b0, 0);   chk(rd[5], 1'b1);
        apb(`RTPM_OFS_MODE, 1'b1, 0);
        apb(`RTPM_OFS_DATA, 1'b1, 9);
        wait_cyc(6000);
        chk(int_gap, 20);
        apb(`RTPM_OFS_DATA, 1'b0, 0);   k = rd;
        apb(`RTPM_OFS_DATA, 1'b0, 0);   chk(rd != k || k == 0, 1'b1);
        apb(`RTPM_OFS_START, 1'b1, 0);
        apb(`RTPM_OFS_DATA, 1'b0, 0);   k = rd;
        wait_cyc(40);
        apb(`RTPM_OFS_DATA, 1'b0, 0);   chk(rd, k);
        // Event counting, falling, rising and both-edge codes
        for (int ec = 0; ec < 3; ec++) begin
            k = ($random(seed) & 7) + 1;
            apb(`RTPM_OFS_START, 1'b1, 0);
            apb(`RTPM_OFS_DATA, 1'b1, 100);
            apb(`RTPM_OFS_MODE, 1'b1, 1 | (ec << 2));
            burst(6, 2);
            apb(`RTPM_OFS_DATA, 1'b0, 0); chk(rd, 100);
            apb(`RTPM_OFS_START, 1'b1, 1);
            burst(6, 2 * k);
            apb(`RTPM_OFS_DATA, 1'b0, 0);
            chk(rd, 100 - (ec == 2 ? 2 * k : k));
        end
        // Event underflow: reload 1, three rising edges, one request
        apb(`RTPM_OFS_START, 1'b1, 0);
        apb(`RTPM_OFS_DATA, 1'b1, 1);
        apb(`RTPM_OFS_MODE, 1'b1, 5);
        apb(`RTPM_OFS_START, 1'b1, 1);
        n0 = ints;
        burst(6, 6);
        chk(ints - n0, 1);
        apb(`RTPM_OFS_DATA, 1'b0, 0);   chk(rd, 0);
        apb(`RTPM_OFS_START, 1'b1, 0);
        apb(`RTPM_OFS_MODE, 1'b1, 3);
        apb(`RTPM_OFS_DATA, 1'b1, 50);
        apb(`RTPM_OFS_START, 1'b1, 1);
        burst(6, 4);
        apb(`RTPM_OFS_DATA, 1'b0, 0);   chk(rd, 50);
        // Period then width measurement
        for (int wm = 0; wm < 2; wm++) begin
            apb(`RTPM_OFS_START, 1'b1, 0);
            apb(`RTPM_OFS_MODE, 1'b1, 2 | (wm << 3));
            apb(`RTPM_OFS_DATA, 1'b1, 0);
            apb(`RTPM_OFS_START, 1'b1, 1);
            n0 = ints;
            burst(8, 8);
            chk(ints - n0, wm ? 7 : 3);
            apb(`RTPM_OFS_DATA, 1'b0, 0);
            k = wm ? 4 : 8;
            chk(rd == k || rd == k - 1, 1'b1);
        end
        apb(`RTPM_OFS_START, 1'b0, 0);  chk(rd, 32'h1);
        // Mid-run reset sets the underflow flag again and stops the timer
        presetn <= 1'b0;
        wait_cyc(5);
        presetn <= 1'b1;
        apb(`RTPM_OFS_MODE, 1'b0, 0);   chk(rd, 32'h20);
        apb(`RTPM_OFS_START, 1'b0, 0);  chk(rd, 32'h0);
        apb(`RTPM_OFS_DATA, 1'b0, 0);   chk(rd, 32'h0);
        test_done();
    end
endmodule
